// ===== verilog/abpm_cfg.svh
`ifndef ABPM_CFG_SVH
`define ABPM_CFG_SVH
// Register indices inside one timeslot
`define ABPM_REG_PTR_CFG      2'h0
`define ABPM_REG_MON_CFG      2'h1
`define ABPM_REG_PTR_ERDI     2'h2
`define ABPM_REG_LABEL        2'h3
// Pointer interpreter config bits
`define ABPM_B_SS_CHECK       1
`define ABPM_B_JUST_DIS       2
`define ABPM_B_FAST_AIS       3
`define ABPM_B_INV_RST        4
`define ABPM_B_NDF_DEF        5
`define ABPM_B_BYPASS         6
`define ABPM_PTR_CFG_MASK     16'h00fe
// Error monitor config bits
`define ABPM_B_LABEL_ALG      0
`define ABPM_B_LABEL_PERS     1
`define ABPM_B_MM_CLR         2
`define ABPM_B_RDI_PERS       3
`define ABPM_B_FS_EXCL        4
`define ABPM_B_BIP_BLK        5
`define ABPM_B_REI_BLK        8
`define ABPM_B_INB_EN         9
`define ABPM_B_INB_BLK        10
`define ABPM_MON_CFG_MASK     16'h0fff
`define ABPM_CFG_RESET        16'h0000
// Pointer constants
`define ABPM_SS_VALID         2'h2
`define ABPM_PTR_MAX          10'h30e
`define ABPM_PTR_MAX_TU3      10'h2fc
`define ABPM_AIS_WORD         16'hffff
`define ABPM_INC_MASK         10'h2aa
`define ABPM_DEC_MASK         10'h155
// Frame counts and the REI limit
`define ABPM_JUST_GAP         3'h3
`define ABPM_AIS_FAST         3'h1
`define ABPM_AIS_SLOW         3'h3
`define ABPM_EQ_NEW           3'h3
`define ABPM_LOP_CNT          4'h8
`define ABPM_LABEL_SHORT      4'h3
`define ABPM_LABEL_LONG       4'h5
`define ABPM_RDI_SHORT        4'h5
`define ABPM_RDI_LONG         4'ha
`define ABPM_REI_MAX          4'h8
`endif

// ===== verilog/abpm_pkg.sv
package abpm_pkg;
  typedef enum logic [1:0] {PTR_NORM, PTR_LOP, PTR_AIS} abpm_ptr_state_t;

  // One frame's overhead for one timeslot
  typedef struct packed {
    logic [3:0]  ts;
    logic [15:0] ptrWord;
    logic [7:0]  c2;
    logic [7:0]  g1;
    logic [7:0]  b3;
    logic [7:0]  parityAll;
    logic [7:0]  parityNoFs;
    logic        vc3;
    logic        tu3;
  } abpm_frame_t;

  // Per-frame result
  typedef struct packed {
    logic [3:0]      ts;
    logic [7:0]      g1Out;
    logic [3:0]      bipCount;
    logic [3:0]      reiCount;
    abpm_ptr_state_t ptrState;
    logic            mismatch;
    logic            unequipped;
    logic            payloadDefect;
  } abpm_result_t;

  // Per-timeslot state
  typedef struct packed {
    logic [15:0]     ptrCfg;
    logic [15:0]     monCfg;
    abpm_ptr_state_t ptrState;
    logic [9:0]      activePtr;
    logic [9:0]      currentPtr;
    logic [1:0]      currentSs;
    logic [2:0]      justAge;
    logic [2:0]      aisCnt;
    logic [3:0]      invalid_ctr_reset_sel;
    logic [3:0]      newflag_ctr_def_sel;
    logic [2:0]      eqCnt;
    logic [9:0]      candPtr;
    logic [7:0]      labelCand;
    logic [3:0]      labelCnt;
    logic [7:0]      acceptedLabel;
    logic [7:0]      capturedLabel;
    logic [2:0]      g1Cand;
    logic [3:0]      g1Cnt;
    logic [2:0]      filteredErdi;
    logic            mismatch;
  } abpm_slot_t;
endpackage

// ===== verilog/add_bus_pointer_path_monitor.sv
`timescale 1ns/1ps
`include "abpm_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Frame FIFO; ready is registered so it can feed a top-level output
module abpm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
    logic          ready;
  } abpm_fifo_state_t;

  abpm_fifo_state_t stateFf;
  abpm_fifo_state_t nxtState;
  logic [WIDTH-1:0] memFf [DEPTH];
  logic             pushEn;
  logic             popEn;

  assign pushEn   = inValid && stateFf.ready;
  assign popEn    = outReady && (stateFf.count != '0);
  assign inReady  = stateFf.ready;
  assign outValid = stateFf.count != '0;
  assign outData  = memFf[stateFf.rdPtr];

  // Pointer and level bookkeeping
  always_comb
  begin
    nxtState = stateFf;
    if (pushEn)
      nxtState.wrPtr = stateFf.wrPtr + 1'b1;
    if (popEn)
      nxtState.rdPtr = stateFf.rdPtr + 1'b1;
    nxtState.count = stateFf.count + {{AW{1'b0}}, pushEn} - {{AW{1'b0}}, popEn};
    nxtState.ready = nxtState.count != (AW + 1)'(DEPTH);
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      stateFf <= '{wrPtr: '0, rdPtr: '0, count: '0, ready: 1'b1};
    else
      stateFf <= nxtState;
    if (pushEn)
      memFf[stateFf.wrPtr] <= inData;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - With SS check on, pointer indications other than AIS need SS equal 10, else SS ignored
// - Without spacing disable, inc/dec within 3 frames of last adjustment is invalid
// - With spacing disable, inc/dec every frame; new-data accepted any frame
// - Enter AIS after 1 indication in fast mode, 3 otherwise
// - Optionally clear invalid counter on 3 identical new pointers
// - New-data counter definition optionally also counts offsets outside legal range
// - Bypass bit disables pointer interpreter for its timeslot
// - Label algorithm select changes mismatch and payload defect definitions
// - Accept label after 5 equal frames, or 3
// - Optionally end mismatch defect when unequipped is declared
// - Accept RDI/ERDI after 10 equal G1 patterns, or 5
// - Optionally exclude fixed stuff from VC-3 parity
// - Parity errors counted as blocks (max 1) or bits (max 8)
// - REI counted as blocks (max 1) or bits (max 8)
// - In-band mode rewrites outgoing G1 with REI and ERDI
// - In-band REI inserted as blocks or bits
// - Report current 10-bit pointer
// - Report current 2-bit SS value
// - Hold filtered 3-bit ERDI updated only after persistence
// - Accepted label in low byte of label register
// - Captured label every frame in high byte of label register
module add_bus_pointer_path_monitor #(
  parameter int         NUM_SLOTS      = 12,
  parameter int         FIFO_DEPTH     = 4,
  parameter logic [7:0] EXPECTED_LABEL = 8'h01
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // Indirect register access
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  input  wire logic [3:0]            regSlot,
  input  wire logic [1:0]            regIdx,
  input  wire logic [15:0]           regWdata,
  output logic [15:0]                regRdata,
  output logic                       regRvalid,
  // Frame overhead stream in
  input  wire logic                  frameValid,
  output logic                       frameReady,
  input  wire abpm_pkg::abpm_frame_t frameData,
  // Result stream out
  output logic                       resValid,
  input  wire logic                  resReady,
  output abpm_pkg::abpm_result_t     resData
);
  typedef struct packed {
    abpm_pkg::abpm_slot_t [NUM_SLOTS-1:0] slot;
    logic [15:0]                          rdata;
    logic                                 rvalid;
    logic                                 resValid;
    abpm_pkg::abpm_result_t               res;
  } abpm_top_state_t;

  abpm_top_state_t       stateFf;
  abpm_top_state_t       nxtState;
  logic                  fifoReady;
  logic                  qValid;
  abpm_pkg::abpm_frame_t q;
  logic                  take;

  // Normal NDF codes and enabled NDF codes (one bit of tolerance)
  function automatic logic ndfNormal(input logic [3:0] n);
    return n inside {4'h6, 4'he, 4'h2, 4'h4, 4'h7};
  endfunction
  function automatic logic ndfEnabled(input logic [3:0] n);
    return n inside {4'h9, 4'h1, 4'hd, 4'hb, 4'h8};
  endfunction
  function automatic logic [3:0] popCount(input logic [7:0] v);
    logic [3:0] c;
    c = '0;
    for (int i = 0; i < 8; i++)
      c = c + {3'h0, v[i]};
    return c;
  endfunction

  abpm_fifo #(.WIDTH($bits(abpm_pkg::abpm_frame_t)), .DEPTH(FIFO_DEPTH)) frameFifo (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .inValid  (frameValid),
    .inReady  (fifoReady),
    .inData   (frameData),
    .outValid (qValid),
    .outReady (take),
    .outData  (q)
  );

  // A frame is taken only when the result register can be refilled
  assign take       = qValid && (!stateFf.resValid || resReady);
  assign frameReady = fifoReady;
  assign regRdata   = stateFf.rdata;
  assign regRvalid  = stateFf.rvalid;
  assign resValid   = stateFf.resValid;
  assign resData    = stateFf.res;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame processing and register access
  always_comb
  begin
    abpm_pkg::abpm_slot_t s;
    logic [9:0] ptr;
    logic [1:0] ss;
    logic [9:0] maxPtr;
    logic       ssOk;
    logic       isAis;
    logic       isNorm;
    logic       isInc;
    logic       isDec;
    logic       isNew;
    logic       isNdf;
    logic       ndfForLop;
    logic       justOk;
    logic       isInv;
    logic [2:0] aisNeed;
    logic [3:0] labelNeed;
    logic [3:0] rdiNeed;
    logic [7:0] bipErr;
    logic [3:0] bipCnt;
    logic [3:0] reiRaw;
    logic [3:0] reiCnt;
    logic [3:0] reiIns;
    logic       uneq;
    logic       pdi;
    logic [2:0] erdiOut;
    s = '0;
    ptr = '0; ss = '0; maxPtr = '0; ssOk = 1'b0; isAis = 1'b0; isNorm = 1'b0;
    isInc = 1'b0; isDec = 1'b0; isNew = 1'b0; isNdf = 1'b0; ndfForLop = 1'b0;
    justOk = 1'b0; isInv = 1'b0; aisNeed = '0; labelNeed = '0; rdiNeed = '0;
    bipErr = '0; bipCnt = '0; reiRaw = '0; reiCnt = '0; reiIns = '0;
    uneq = 1'b0; pdi = 1'b0; erdiOut = '0;
    nxtState = stateFf;
    nxtState.rvalid = 1'b0;
    if (resReady)
      nxtState.resValid = 1'b0;

    // Per-timeslot register write; reserved bits masked to zero
    if (regWr && 32'(regSlot) < NUM_SLOTS)
    begin
      if (regIdx == `ABPM_REG_PTR_CFG)
        nxtState.slot[regSlot].ptrCfg = regWdata & `ABPM_PTR_CFG_MASK;
      else if (regIdx == `ABPM_REG_MON_CFG)
        nxtState.slot[regSlot].monCfg = regWdata & `ABPM_MON_CFG_MASK;
    end

    if (take && 32'(q.ts) < NUM_SLOTS)
    begin
      s      = stateFf.slot[q.ts];
      ptr    = q.ptrWord[9:0];
      ss     = q.ptrWord[11:10];
      maxPtr = q.tu3 ? `ABPM_PTR_MAX_TU3 : `ABPM_PTR_MAX;
      // Pointer indications
      ssOk   = !s.ptrCfg[`ABPM_B_SS_CHECK] || ss == `ABPM_SS_VALID;
      isAis  = q.ptrWord == `ABPM_AIS_WORD;
      isNorm = ndfNormal(q.ptrWord[15:12]) && ssOk && ptr == s.activePtr;
      isInc  = ndfNormal(q.ptrWord[15:12]) && ssOk && (ptr ^ s.activePtr) == `ABPM_INC_MASK;
      isDec  = ndfNormal(q.ptrWord[15:12]) && ssOk && (ptr ^ s.activePtr) == `ABPM_DEC_MASK;
      isNew  = ndfNormal(q.ptrWord[15:12]) && ssOk && ptr <= maxPtr && !isNorm && !isInc && !isDec;
      isNdf  = ndfEnabled(q.ptrWord[15:12]) && ssOk && ptr <= maxPtr;
      ndfForLop = ndfEnabled(q.ptrWord[15:12]) && ssOk &&
                  (s.ptrCfg[`ABPM_B_NDF_DEF] || ptr <= maxPtr);
      // Spacing check against last adjustment
      justOk = s.ptrCfg[`ABPM_B_JUST_DIS] || s.justAge >= `ABPM_JUST_GAP;
      isInv  = !isAis && !isNorm && !isNew && !isNdf && !((isInc || isDec) && justOk);
      s.currentPtr = ptr;
      s.currentSs  = ss;
      aisNeed = s.ptrCfg[`ABPM_B_FAST_AIS] ? `ABPM_AIS_FAST : `ABPM_AIS_SLOW;
      if (s.ptrCfg[`ABPM_B_BYPASS])
      begin
        s.ptrState = abpm_pkg::PTR_NORM;
        s.aisCnt = '0; s.invalid_ctr_reset_sel = '0; s.newflag_ctr_def_sel = '0; s.eqCnt = '0;
      end
      else
      begin
        s.justAge = (s.justAge == 3'h7) ? s.justAge : s.justAge + 3'h1;
        s.aisCnt  = isAis ? ((s.aisCnt == 3'h7) ? s.aisCnt : s.aisCnt + 3'h1) : '0;
        s.invalid_ctr_reset_sel  = isInv ? s.invalid_ctr_reset_sel + 4'h1 : '0;
        s.newflag_ctr_def_sel  = ndfForLop ? s.newflag_ctr_def_sel + 4'h1 : '0;
        if (isNew)
        begin
          s.eqCnt   = (ptr == s.candPtr) ? s.eqCnt + 3'h1 : 3'h1;
          s.candPtr = ptr;
        end
        else
          s.eqCnt = '0;
        if (s.aisCnt >= aisNeed)
          s.ptrState = abpm_pkg::PTR_AIS;
        else if ((isInc || isDec) && justOk && s.ptrState == abpm_pkg::PTR_NORM)
        begin
          s.activePtr = isInc ? s.activePtr + 10'h1 : s.activePtr - 10'h1;
          s.justAge = '0;
        end
        else if (isNdf)
        begin
          s.activePtr = ptr;
          s.justAge = '0;
          s.ptrState = abpm_pkg::PTR_NORM;
        end
        else if (s.eqCnt == `ABPM_EQ_NEW)
        begin
          s.activePtr = ptr;
          s.ptrState = abpm_pkg::PTR_NORM;
          if (s.ptrCfg[`ABPM_B_INV_RST])
            s.invalid_ctr_reset_sel = '0;
        end
        if (s.invalid_ctr_reset_sel == `ABPM_LOP_CNT || s.newflag_ctr_def_sel == `ABPM_LOP_CNT)
          s.ptrState = abpm_pkg::PTR_LOP;
      end

      // Signal label persistence
      s.capturedLabel = q.c2;
      labelNeed = s.monCfg[`ABPM_B_LABEL_PERS] ? `ABPM_LABEL_LONG : `ABPM_LABEL_SHORT;
      s.labelCnt = (q.c2 == s.labelCand && s.labelCnt != 4'hf) ? s.labelCnt + 4'h1 : 4'h1;
      s.labelCand = q.c2;
      if (s.labelCnt >= labelNeed)
        s.acceptedLabel = s.labelCand;
      uneq = s.acceptedLabel == 8'h00;
      // Algorithm 1 reads E1..FC as a payload defect, not a mismatch
      pdi = !s.monCfg[`ABPM_B_LABEL_ALG] && s.acceptedLabel >= 8'he1 && s.acceptedLabel <= 8'hfc;
      if (!uneq && !pdi && s.acceptedLabel != EXPECTED_LABEL)
        s.mismatch = 1'b1;
      else if (uneq && s.monCfg[`ABPM_B_MM_CLR])
        s.mismatch = 1'b0;
      else if (!uneq)
        s.mismatch = 1'b0;

      // RDI/ERDI persistence on G1 bits 5..7
      rdiNeed = s.monCfg[`ABPM_B_RDI_PERS] ? `ABPM_RDI_LONG : `ABPM_RDI_SHORT;
      s.g1Cnt = (q.g1[3:1] == s.g1Cand && s.g1Cnt != 4'hf) ? s.g1Cnt + 4'h1 : 4'h1;
      s.g1Cand = q.g1[3:1];
      if (s.g1Cnt >= rdiNeed)
        s.filteredErdi = s.g1Cand;

      // Parity, fixed stuff only dropped for VC-3 payloads
      bipErr = ((q.vc3 && s.monCfg[`ABPM_B_FS_EXCL]) ? q.parityNoFs : q.parityAll) ^ q.b3;
      bipCnt = s.monCfg[`ABPM_B_BIP_BLK] ? {3'h0, |bipErr} : popCount(bipErr);
      // REI values above 8 carry no errors
      reiRaw = (q.g1[7:4] > `ABPM_REI_MAX) ? 4'h0 : q.g1[7:4];
      reiCnt = s.monCfg[`ABPM_B_REI_BLK] ? {3'h0, reiRaw != 4'h0} : reiRaw;
      reiIns = s.monCfg[`ABPM_B_INB_BLK] ? {3'h0, |bipErr} : popCount(bipErr);
      // Server defect outranks payload defects in the returned ERDI code
      if (s.ptrState != abpm_pkg::PTR_NORM)
        erdiOut = 3'h5;
      else if (uneq || s.mismatch)
        erdiOut = 3'h2;
      else
        erdiOut = 3'h1;

      nxtState.res.ts            = q.ts;
      nxtState.res.g1Out         = s.monCfg[`ABPM_B_INB_EN] ? {reiIns, erdiOut, q.g1[0]} : q.g1;
      nxtState.res.bipCount      = bipCnt;
      nxtState.res.reiCount      = reiCnt;
      nxtState.res.ptrState      = s.ptrState;
      nxtState.res.mismatch      = s.mismatch;
      nxtState.res.unequipped    = uneq;
      nxtState.res.payloadDefect = pdi;
      nxtState.resValid          = 1'b1;
      // Keep any same-cycle config write
      s.ptrCfg = nxtState.slot[q.ts].ptrCfg;
      s.monCfg = nxtState.slot[q.ts].monCfg;
      nxtState.slot[q.ts] = s;
    end
    else if (take)
      nxtState.resValid = 1'b0;

    // Read returns one cycle later; unmapped slot reads zero
    if (regRd)
    begin
      nxtState.rvalid = 1'b1;
      nxtState.rdata  = '0;
      if (32'(regSlot) < NUM_SLOTS)
        unique case (regIdx)
          `ABPM_REG_PTR_CFG:  nxtState.rdata = stateFf.slot[regSlot].ptrCfg;
          `ABPM_REG_MON_CFG:  nxtState.rdata = stateFf.slot[regSlot].monCfg;
          `ABPM_REG_PTR_ERDI: nxtState.rdata = {stateFf.slot[regSlot].filteredErdi, 1'b0,
                                                stateFf.slot[regSlot].currentSs,
                                                stateFf.slot[regSlot].currentPtr};
          `ABPM_REG_LABEL:    nxtState.rdata = {stateFf.slot[regSlot].capturedLabel,
                                                stateFf.slot[regSlot].acceptedLabel};
        endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      stateFf <= '0;
    else
      stateFf <= nxtState;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  abpm_pkg::abpm_slot_t pre;
  abpm_pkg::abpm_slot_t post;
  logic                 procOk;
  assign procOk = take && 32'(q.ts) < NUM_SLOTS && !(regWr && regSlot == q.ts);
  assign pre    = stateFf.slot[q.ts];
  assign post   = nxtState.slot[q.ts];

  // Any enabled new-data code, SS aside; such a frame may move the pointer
  logic isNdfSig;
  assign isNdfSig = ndfEnabled(q.ptrWord[15:12]);

  ss_check_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    procOk && pre.ptrCfg[`ABPM_B_SS_CHECK] && q.ptrWord[11:10] != `ABPM_SS_VALID && !pre.ptrCfg[`ABPM_B_BYPASS]
    |-> post.activePtr == pre.activePtr || post.ptrState != abpm_pkg::PTR_NORM)
    else $error("pointer moved with bad SS");
  just_spacing_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    procOk && !pre.ptrCfg[`ABPM_B_JUST_DIS] && pre.justAge < `ABPM_JUST_GAP && !isNdfSig
    && pre.ptrState == abpm_pkg::PTR_NORM && post.ptrState == abpm_pkg::PTR_NORM && pre.eqCnt < 3'h2
    |-> post.activePtr == pre.activePtr)
    else $error("justification accepted too soon");
  ais_entry_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    procOk && !pre.ptrCfg[`ABPM_B_BYPASS] && q.ptrWord == `ABPM_AIS_WORD && pre.ptrCfg[`ABPM_B_FAST_AIS]
    |=> stateFf.slot[$past(q.ts)].ptrState == abpm_pkg::PTR_AIS)
    else $error("fast AIS entry missed");
  bypass_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    procOk && pre.ptrCfg[`ABPM_B_BYPASS] |-> post.ptrState == abpm_pkg::PTR_NORM && post.invalid_ctr_reset_sel == 4'h0)
    else $error("bypassed slot still interpreting");
  label_persist_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    procOk && post.acceptedLabel != pre.acceptedLabel
    |-> post.labelCnt >= (pre.monCfg[`ABPM_B_LABEL_PERS] ? `ABPM_LABEL_LONG : `ABPM_LABEL_SHORT))
    else $error("label accepted without persistence");
  erdi_persist_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    procOk && post.filteredErdi != pre.filteredErdi
    |-> post.g1Cnt >= (pre.monCfg[`ABPM_B_RDI_PERS] ? `ABPM_RDI_LONG : `ABPM_RDI_SHORT))
    else $error("ERDI updated without persistence");
  block_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    procOk && pre.monCfg[`ABPM_B_BIP_BLK] && pre.monCfg[`ABPM_B_REI_BLK]
    |=> resValid && resData.bipCount <= 4'h1 && resData.reiCount <= 4'h1)
    else $error("block count above one");
  g1_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    procOk && !pre.monCfg[`ABPM_B_INB_EN] |=> resData.g1Out == $past(q.g1))
    else $error("G1 altered with in-band off");
  capture_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    procOk |=> stateFf.slot[$past(q.ts)].capturedLabel == $past(q.c2))
    else $error("label not captured");
  read_ptr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    regRd && regIdx == `ABPM_REG_PTR_ERDI && 32'(regSlot) < NUM_SLOTS
    |=> regRvalid && regRdata[11:0] == {$past(stateFf.slot[regSlot].currentSs), $past(stateFf.slot[regSlot].currentPtr)})
    else $error("pointer readback wrong");

  ais_seen_c: cover property (@(posedge sys_clk) disable iff (sys_rst) resValid && resData.ptrState == abpm_pkg::PTR_AIS);
  lop_seen_c: cover property (@(posedge sys_clk) disable iff (sys_rst) resValid && resData.ptrState == abpm_pkg::PTR_LOP);
  fifo_full_c: cover property (@(posedge sys_clk) disable iff (sys_rst) !frameReady);
  mismatch_c: cover property (@(posedge sys_clk) disable iff (sys_rst) resValid && resData.mismatch);
endmodule

// ===== test/abpm_frame_src.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Upstream add-bus source: one overhead word per timeslot per frame
module abpm_frame_src (
  // Clock
  input  wire logic              sys_clk,
  // Stream toward the block
  output logic                   frameValid,
  input  wire logic              frameReady,
  output abpm_pkg::abpm_frame_t  frameData
);
  // Idle bus shows junk, never a stale word
  initial frameValid = 1'b0;
  initial frameData = '1;

  // Offer a word and hold it until the ready edge; valid stays up for back-to-back
  // Ready is registered, so it is read settled between edges, never at one
  task automatic send(input abpm_pkg::abpm_frame_t f);
    frameValid = 1'b1;
    frameData = f;
    while (frameReady !== 1'b1)
    begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1;
  endtask

  // Release the bus; data inverted so it cannot pass for a fresh word
  task automatic idle();
    frameValid = 1'b0;
    frameData = ~frameData;
  endtask
endmodule

// ===== test/test_add_bus_pointer_path_monitor.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module test_add_bus_pointer_path_monitor;
  typedef struct packed {logic [15:0] cfg; logic vc3; logic [3:0] bip, rei, g1hi;} abpm_row_t;

  logic                   sys_clk = 1'b0, sys_rst = 1'b1;
  logic                   regWr = 1'b0, regRd = 1'b0, resReady = 1'b1;
  logic [3:0]             regSlot = 4'h0;
  logic [1:0]             regIdx = 2'h0;
  logic [15:0]            regWdata = 16'h0000, regRdata, rv;
  logic                   regRvalid, frameValid, frameReady, resValid;
  abpm_pkg::abpm_frame_t  frameData;
  abpm_pkg::abpm_result_t resData, r;
  abpm_pkg::abpm_result_t resQ[$];
  int                     errors = 0, comparisons = 0, cycles = 0, i;
  // Monitor config rows: b3 00, full parity 07, parity without stuff 01, G1 51
  abpm_row_t rows[7] = '{'{16'h0000, 1'b0, 4'h3, 4'h5, 4'h5}, '{16'h0120, 1'b0, 4'h1, 4'h1, 4'h5},
    '{16'h0100, 1'b0, 4'h3, 4'h1, 4'h5}, '{16'h0010, 1'b1, 4'h1, 4'h5, 4'h5},
    '{16'h0010, 1'b0, 4'h3, 4'h5, 4'h5}, '{16'h0200, 1'b0, 4'h3, 4'h5, 4'h3},
    '{16'h0600, 1'b0, 4'h3, 4'h5, 4'h1}};

  add_bus_pointer_path_monitor dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regWr(regWr), .regRd(regRd),
    .regSlot(regSlot), .regIdx(regIdx), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .frameValid(frameValid), .frameReady(frameReady), .frameData(frameData), .resValid(resValid),
    .resReady(resReady), .resData(resData));
  abpm_frame_src src (.sys_clk(sys_clk), .frameValid(frameValid), .frameReady(frameReady), .frameData(frameData));

  // Clock, result capture and hang guard
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (resValid === 1'b1 && resReady === 1'b1) resQ.push_back(resData);
    if (cycles == 20000)
    begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) errors++;
    if (seen !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
  endtask

  // One register op; the extra edge keeps strobes from being set twice in a step
  task automatic acc(input logic w, input logic [3:0] s, input logic [1:0] x, input logic [15:0] d);
    regWr = w;
    regRd = !w;
    regSlot = s;
    regIdx = x;
    regWdata = d;
    @(posedge sys_clk);
    #1;
    regWr = 1'b0;
    regRd = 1'b0;
    rv = regRdata;
    if (!w) chk("regRvalid", 16'(regRvalid), 16'h0001);
    @(posedge sys_clk);
    #1;
  endtask

  task automatic rdchk(input logic [3:0] s, input logic [1:0] x, input logic [15:0] e);
    acc(1'b0, s, x, 16'h0000);
    chk("register", rv, e);
  endtask

  function automatic abpm_pkg::abpm_frame_t mk(input logic [3:0] ts, input logic [15:0] pw,
    input logic [7:0] c2, g1, input logic vc3);
    return '{ts, pw, c2, g1, 8'h00, 8'h07, 8'h01, vc3, 1'b0};
  endfunction

  task automatic push(input abpm_pkg::abpm_frame_t f, input int n);
    resQ.delete();
    repeat (n) src.send(f);
    src.idle();
  endtask

  // Bounded wait for n results, keep the last
  task automatic collect(input int n);
    for (int k = 0; k < 60 && resQ.size() < n; k++) @(posedge sys_clk);
    #1;
    chk("results", 16'(resQ.size()), 16'(n));
    r = resQ[$];
  endtask

  task automatic frames(input logic [3:0] ts, input logic [15:0] pw, input logic [7:0] c2, g1, input int n);
    push(mk(ts, pw, c2, g1, 1'b0), n);
    collect(n);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    for (i = 0; i < 7; i++)
    begin
      acc(1'b1, 4'h7, 2'h1, rows[i].cfg);
      push(mk(4'h7, 16'h6923, 8'h00, 8'h51, rows[i].vc3), 1);
      collect(1);
      chk("bipCount", 16'(r.bipCount), 16'(rows[i].bip));
      chk("reiCount", 16'(r.reiCount), 16'(rows[i].rei));
      chk("g1Out", 16'(r.g1Out), 16'({rows[i].g1hi, (rows[i].cfg[9] ? 3'h2 : 3'h0), 1'b1}));
    end
    $display("test monitor rows done");
    rdchk(4'h1, 2'h0, 16'h0000);
    acc(1'b1, 4'h1, 2'h0, 16'hffff);
    rdchk(4'h1, 2'h0, 16'h00fe);
    acc(1'b1, 4'h1, 2'h1, 16'hffff);
    rdchk(4'h1, 2'h1, 16'h0fff);
    acc(1'b1, 4'hc, 2'h0, 16'hffff);
    rdchk(4'hc, 2'h0, 16'h0000);
    rdchk(4'h2, 2'h0, 16'h0000);
    $display("test registers done");
    frames(4'h3, 16'h6923, 8'h13, 8'h00, 2);
    rdchk(4'h3, 2'h3, 16'h1300);
    chk("unequipped", 16'(r.unequipped), 16'h0001);
    frames(4'h3, 16'h6923, 8'h13, 8'h00, 1);
    rdchk(4'h3, 2'h3, 16'h1313);
    chk("mismatch", 16'(r.mismatch), 16'h0001);
    acc(1'b1, 4'h3, 2'h1, 16'h0002);
    frames(4'h3, 16'h6923, 8'h55, 8'h00, 4);
    rdchk(4'h3, 2'h3, 16'h5513);
    frames(4'h3, 16'h6923, 8'h55, 8'h00, 1);
    rdchk(4'h3, 2'h3, 16'h5555);
    frames(4'h3, 16'h6923, 8'h00, 8'h00, 5);
    chk("mismatch", 16'(r.mismatch), 16'h0001);
    chk("unequipped", 16'(r.unequipped), 16'h0001);
    acc(1'b1, 4'h3, 2'h1, 16'h0006);
    frames(4'h3, 16'h6923, 8'h00, 8'h00, 1);
    chk("mismatch", 16'(r.mismatch), 16'h0000);
    $display("test labels done");
    frames(4'h4, 16'h6923, 8'h00, 8'h0a, 4);
    rdchk(4'h4, 2'h2, 16'h0923);
    frames(4'h4, 16'h6923, 8'h00, 8'h0a, 1);
    rdchk(4'h4, 2'h2, 16'ha923);
    acc(1'b1, 4'h4, 2'h1, 16'h0008);
    frames(4'h4, 16'h6923, 8'h00, 8'h04, 9);
    rdchk(4'h4, 2'h2, 16'ha923);
    frames(4'h4, 16'h6923, 8'h00, 8'h04, 1);
    rdchk(4'h4, 2'h2, 16'h4923);
    $display("test erdi done");
    frames(4'h5, 16'hffff, 8'h00, 8'h00, 2);
    chk("ptrState", 16'(r.ptrState), 16'(abpm_pkg::PTR_NORM));
    frames(4'h5, 16'hffff, 8'h00, 8'h00, 1);
    chk("ptrState", 16'(r.ptrState), 16'(abpm_pkg::PTR_AIS));
    acc(1'b1, 4'h6, 2'h0, 16'h0008);
    frames(4'h6, 16'hffff, 8'h00, 8'h00, 1);
    chk("ptrState", 16'(r.ptrState), 16'(abpm_pkg::PTR_AIS));
    acc(1'b1, 4'h8, 2'h0, 16'h0040);
    frames(4'h8, 16'hffff, 8'h00, 8'h00, 3);
    chk("ptrState", 16'(r.ptrState), 16'(abpm_pkg::PTR_NORM));
    acc(1'b1, 4'ha, 2'h0, 16'h0002);
    frames(4'ha, 16'h6123, 8'h00, 8'h00, 8);
    chk("ptrState", 16'(r.ptrState), 16'(abpm_pkg::PTR_LOP));
    frames(4'hb, 16'h6123, 8'h00, 8'h00, 8);
    chk("ptrState", 16'(r.ptrState), 16'(abpm_pkg::PTR_NORM));
    $display("test pointer done");
    resReady = 1'b0;
    push(mk(4'h9, 16'h6923, 8'h00, 8'h00, 1'b0), 5);
    @(posedge sys_clk);
    #1;
    chk("frameReady", 16'(frameReady), 16'h0000);
    resReady = 1'b1;
    collect(5);
    $display("test stall done");
    print_verdict();
  end
endmodule
